// file: core/sem_host.sv
`timescale 1ns/1ns
`include "sem_host_cfg.svh"
// Behaviour
// - controller deasserts select between successive reads.
// - controller writes zero first, then reads back to test success.
// - after failure the request stays pending; a poll command re-reads, a release command writes one to withdraw.
// - at start-up controller writes one to all eight flags.
module sem_host
   import sem_host_pkg::*;
#(
   parameter int SETUP = `SETUP_CYC
) (
   // clock and reset
   input  wire logic               clk_in,
   input  wire logic               arst_n_in,
   // command port
   input  wire logic               cmd_valid_in,
   input  wire sem_host_pkg::cmd_s cmd_in,
   output logic                    cmd_ready_out,
   output logic                    rsp_valid_out,
   output sem_host_pkg::rsp_s      rsp_out,
   output logic                    init_done_out,
   // device pins
   output sem_host_pkg::pins_s     pins_out,
   input  wire logic [`DATA_W-1:0] dev_data_in
);
   import sem_host_pkg::*;

   typedef enum logic [2:0] {
      ST_INIT  = 3'b000,
      ST_IDLE  = 3'b001,
      ST_WRITE = 3'b010,
      ST_GAP   = 3'b011,
      ST_READ  = 3'b100,
      ST_DONE  = 3'b101
   } st_e;

   st_e                    st_r;
   op_e                    op_r;
   logic [`FLAG_IDX_W-1:0] idx_r;
   logic                   wval_r;
   logic                   pending_r;
   logic                   start;
   logic                   tick;
   logic                   rd_flag;
   rsp_s                   rsp_r;
   logic                   rsp_v_r;
   logic                   init_r;

   sem_cycle_timer #(.CYC(SETUP)) u_timer (
      .clk_in    (clk_in),
      .arst_n_in (arst_n_in),
      .start_in  (start),
      .done_out  (tick)
   );

   // device returns flag on every bit; bit 0 is enough
   assign rd_flag = dev_data_in[0];
   assign cmd_ready_out = (st_r == ST_IDLE);
   assign start = (st_r == ST_IDLE && cmd_valid_in) ||
                  (st_r == ST_INIT && !init_r && !pending_r) ||
                  (st_r == ST_WRITE && tick) ||
                  (st_r == ST_GAP && tick);

   // sequencer
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         st_r      <= ST_INIT;
         op_r      <= OP_INIT;
         idx_r     <= '0;
         wval_r    <= `FLAG_FREE_BIT;
         pending_r <= 1'b0;
         init_r    <= 1'b0;
      end else begin
         case (st_r)
            ST_INIT: begin
               // device latches have no reset: free them all first
               if (!pending_r) begin
                  st_r      <= ST_WRITE;
                  wval_r    <= `FLAG_FREE_BIT;
                  pending_r <= 1'b1;
               end else if (idx_r == `FLAG_IDX_W'(`FLAG_COUNT - 1)) begin
                  st_r   <= ST_IDLE;
                  init_r <= 1'b1;
                  idx_r  <= '0;
               end else begin
                  idx_r     <= idx_r + 1'b1;
                  pending_r <= 1'b0;
               end
            end
            ST_IDLE: begin
               pending_r <= 1'b0;
               if (cmd_valid_in) begin
                  op_r  <= cmd_in.op;
                  idx_r <= cmd_in.idx;
                  // acquire: write zero first, never read first
                  if (cmd_in.op == OP_POLL) begin
                     st_r <= ST_READ;
                  end else begin
                     st_r   <= ST_WRITE;
                     wval_r <= (cmd_in.op == OP_ACQUIRE) ? `FLAG_TAKE_BIT
                                                         : `FLAG_FREE_BIT;
                  end
               end
            end
            ST_WRITE: begin
               if (tick) begin
                  if (!init_r) st_r <= ST_INIT;
                  else if (op_r == OP_ACQUIRE) st_r <= ST_GAP;
                  else st_r <= ST_DONE;
               end
            end
            // select released so the read latch recaptures
            ST_GAP: if (tick) st_r <= ST_READ;
            ST_READ: if (tick) st_r <= ST_DONE;
            ST_DONE: st_r <= ST_IDLE;
            default: st_r <= ST_INIT;
         endcase
      end
   end

   // read sample and answer
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         rsp_r   <= '0;
         rsp_v_r <= 1'b0;
      end else begin
         rsp_v_r <= 1'b0;
         if (st_r == ST_READ && tick) begin
            rsp_v_r       <= 1'b1;
            rsp_r.idx     <= idx_r;
            rsp_r.granted <= (rd_flag == `FLAG_TAKE_BIT);
            rsp_r.failed  <= (rd_flag == `FLAG_FREE_BIT);
         end else if (st_r == ST_WRITE && tick && init_r && op_r != OP_ACQUIRE) begin
            rsp_v_r       <= 1'b1;
            rsp_r.idx     <= idx_r;
            rsp_r.granted <= 1'b0;
            rsp_r.failed  <= 1'b0;
         end
      end
   end
   // failure leaves the request pending: user must poll or release

   // pin drive; upper address zero, only bit 0 meaningful on writes
   always_comb begin
      pins_out       = '0;
      pins_out.sel_n = 1'b1;
      pins_out.oe_n  = 1'b1;
      pins_out.we_n  = 1'b1;
      pins_out.addr  = {{(`ADDR_W-`FLAG_IDX_W){1'b0}}, idx_r};
      if (st_r == ST_WRITE) begin
         pins_out.sel_n = 1'b0;
         // strobe only in the last setup cycle: address and data settle first
         pins_out.we_n  = !tick;
         pins_out.doe   = 1'b1;
         pins_out.dout  = {{(`DATA_W-1){1'b0}}, wval_r};
      end else if (st_r == ST_READ) begin
         pins_out.sel_n = 1'b0;
         pins_out.oe_n  = 1'b0;
      end
   end

   assign rsp_valid_out = rsp_v_r;
   assign rsp_out       = rsp_r;
   assign init_done_out = init_r;
   // flags steer nothing here; meaning left to user logic

   // acquire: write ends, strobes all drop for the gap, then the read-back follows
   sequence acq_write_end_q;
      st_r == ST_WRITE && tick && op_r == OP_ACQUIRE && init_r;
   endsequence
   sequence strobes_off_q;
      pins_out.sel_n && pins_out.oe_n && pins_out.we_n;
   endsequence
   sequence read_issued_q;
      !pins_out.sel_n && !pins_out.oe_n && pins_out.we_n;
   endsequence

   AST_WRITE_BEFORE_READ: assert property (@(posedge clk_in) disable iff (!arst_n_in)
      (st_r == ST_READ && op_r == OP_ACQUIRE) |-> $past(st_r) != ST_IDLE)
      else $error("acquire read without preceding write");
   AST_GAP_BETWEEN: assert property (@(posedge clk_in) disable iff (!arst_n_in)
      acq_write_end_q |=> strobes_off_q)
      else $error("select not released between write and read");
   AST_ACQ_READBACK: assert property (@(posedge clk_in) disable iff (!arst_n_in)
      acq_write_end_q |-> ##[1:32] read_issued_q)
      else $error("acquire write not followed by read-back");
   AST_WE_UNDER_SEL: assert property (@(posedge clk_in) disable iff (!arst_n_in)
      !pins_out.we_n |-> !pins_out.sel_n && pins_out.oe_n && pins_out.doe)
      else $error("write strobe outside a flag write");
   AST_ADDR_LOW: assert property (@(posedge clk_in) disable iff (!arst_n_in)
      !pins_out.sel_n |-> pins_out.addr[`ADDR_W-1:`FLAG_IDX_W] == '0)
      else $error("upper address not zero");
   AST_DATA_BIT0: assert property (@(posedge clk_in) disable iff (!arst_n_in)
      pins_out.doe |-> pins_out.dout[`DATA_W-1:1] == '0)
      else $error("upper data bits driven");
   AST_ACQ_ZERO: assert property (@(posedge clk_in) disable iff (!arst_n_in)
      (pins_out.doe && init_r && op_r == OP_ACQUIRE) |-> pins_out.dout[0] == 1'b0)
      else $error("acquire wrote one");
   AST_INIT_ONES: assert property (@(posedge clk_in) disable iff (!arst_n_in)
      (pins_out.doe && !init_r) |-> pins_out.dout[0] == 1'b1)
      else $error("init wrote zero");
   AST_GRANT_FLAG: assert property (@(posedge clk_in) disable iff (!arst_n_in)
      (st_r == ST_READ && tick) |=> rsp_valid_out && rsp_out.granted == !$past(rd_flag))
      else $error("grant does not match flag");
   AST_READ_STABLE: assert property (@(posedge clk_in) disable iff (!arst_n_in)
      (st_r == ST_READ && !tick) |=> !pins_out.oe_n && !pins_out.sel_n)
      else $error("read strobes dropped early");
endmodule

// file: core/sem_host_cfg.svh
`ifndef SEM_HOST_CFG_SVH
`define SEM_HOST_CFG_SVH
`define FLAG_COUNT      8
`define FLAG_IDX_W      3
`define DATA_W          16
`define ADDR_W          13
`define FLAG_FREE_BIT   1'b1
`define FLAG_TAKE_BIT   1'b0
`define SETUP_NS        8
`define CLK_NS          4
`define SETUP_CYC       ((`SETUP_NS + `CLK_NS - 1) / `CLK_NS)
`define CNT_W           4
`endif

// file: core/sem_host_pkg.sv
`include "sem_host_cfg.svh"
package sem_host_pkg;
   typedef enum logic [1:0] {
      OP_ACQUIRE = 2'b00,
      OP_RELEASE = 2'b01,
      OP_POLL    = 2'b10,
      OP_INIT    = 2'b11
   } op_e;
   typedef struct packed {
      op_e                    op;
      logic [`FLAG_IDX_W-1:0] idx;
   } cmd_s;
   typedef struct packed {
      logic                   granted;
      logic                   failed;
      logic [`FLAG_IDX_W-1:0] idx;
   } rsp_s;
   typedef struct packed {
      logic                   sel_n;
      logic                   oe_n;
      logic                   we_n;
      logic [`ADDR_W-1:0]     addr;
      logic [`DATA_W-1:0]     dout;
      logic                   doe;
   } pins_s;
endpackage

// file: core/sem_cycle_timer.sv
`timescale 1ns/1ns
`include "sem_host_cfg.svh"
module sem_cycle_timer #(
   parameter int CYC = `SETUP_CYC
) (
   // clock and reset
   input  wire logic clk_in,
   input  wire logic arst_n_in,
   // control
   input  wire logic start_in,
   output logic      done_out
);
   logic [`CNT_W-1:0] cnt_r;
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         cnt_r <= '0;
      end else if (start_in) begin
         cnt_r <= `CNT_W'(CYC);
      end else if (cnt_r != '0) begin
         cnt_r <= cnt_r - 1'b1;
      end
   end
   assign done_out = (cnt_r == `CNT_W'(1));
endmodule

// file: tb/sem_dev_model.sv
`timescale 1ns/1ns
`include "sem_host_cfg.svh"
module sem_dev_model
   import sem_host_pkg::*;
(
   // clock
   input  wire logic                clk_in,
   // left port, the controller
   input  wire sem_host_pkg::pins_s lp_in,
   output logic [`DATA_W-1:0]       ld_out,
   // right port, the bench
   input  wire logic                rsel_n_in,
   input  wire logic                roe_n_in,
   input  wire logic                rwe_n_in,
   input  wire logic [`ADDR_W-1:0]  raddr_in,
   input  wire logic [`DATA_W-1:0]  rdin_in,
   output logic [`DATA_W-1:0]       rd_out
);
   // no power-on clear: every latch starts as a pending request
   logic [`FLAG_COUNT-1:0] req_l_r  = '0;
   logic [`FLAG_COUNT-1:0] req_r_r  = '0;
   logic [`FLAG_COUNT-1:0] hold_l_r = '0;
   logic [`FLAG_COUNT-1:0] hold_r_r = '0;
   logic                   lat_l_r  = 1'b0;
   logic                   lat_r_r  = 1'b0;
   wire                    left_act  = !lp_in.sel_n && !lp_in.oe_n;
   wire                    right_act = !rsel_n_in && !roe_n_in;

   // flags only; nothing else in the part is gated by them
   always @(posedge clk_in) begin
      if (!lp_in.sel_n && !lp_in.we_n)
         req_l_r[lp_in.addr[2:0]] = lp_in.dout[0];
      if (!rsel_n_in && !rwe_n_in)
         req_r_r[raddr_in[2:0]] = rdin_in[0];
      for (int i = 0; i < `FLAG_COUNT; i++) begin
         if (hold_l_r[i] && req_l_r[i])
            hold_l_r[i] = 1'b0;
         if (hold_r_r[i] && req_r_r[i])
            hold_r_r[i] = 1'b0;
         // pending request of the other side takes over at once
         if (!hold_l_r[i] && !hold_r_r[i]) begin
            if (!req_l_r[i])
               hold_l_r[i] = 1'b1; // left wins a same-edge tie
            else if (!req_r_r[i])
               hold_r_r[i] = 1'b1;
         end
      end
   end

   always @(posedge left_act) lat_l_r = ~hold_l_r[lp_in.addr[2:0]];
   always @(posedge right_act) lat_r_r = ~hold_r_r[raddr_in[2:0]];
   // released bus shows the inverse so a stale sample cannot pass
   assign ld_out = left_act ? {`DATA_W{lat_l_r}} : {`DATA_W{~lat_l_r}};
   assign rd_out = right_act ? {`DATA_W{lat_r_r}} : {`DATA_W{~lat_r_r}};
endmodule

// file: tb/tb_top.sv
`timescale 1ns/1ns
`include "sem_host_cfg.svh"
`define CHK(nm, ex, got) begin checks_done++; if ((got) !== (ex)) begin error_cnt++; \
   $display("wrong value %s exp %h got %h", nm, ex, got); end end
module tb_top;
   import sem_host_pkg::*;
   logic clk_in = 1'b0;
   logic arst_n_in, cmd_valid_in, cmd_ready_out, rsp_valid_out, init_done_out;
   cmd_s cmd_in;
   rsp_s rsp_out;
   pins_s pins;
   logic [`DATA_W-1:0] ldata, r_din, r_dout;
   logic [`ADDR_W-1:0] r_addr;
   logic r_sel_n, r_oe_n, r_we_n;
   logic [5:0] exp_q[$];
   logic [5:0] e;
   int error_cnt = 0;
   int checks_done = 0;
   integer seed = 81;
   int k;

   always #2 clk_in = ~clk_in;

   sem_host u_sem_host (.clk_in(clk_in), .arst_n_in(arst_n_in), .cmd_valid_in(cmd_valid_in),
      .cmd_in(cmd_in), .cmd_ready_out(cmd_ready_out), .rsp_valid_out(rsp_valid_out),
      .rsp_out(rsp_out), .init_done_out(init_done_out), .pins_out(pins), .dev_data_in(ldata));
   sem_dev_model u_sem_dev_model (.clk_in(clk_in), .lp_in(pins), .ld_out(ldata),
      .rsel_n_in(r_sel_n), .roe_n_in(r_oe_n), .rwe_n_in(r_we_n), .raddr_in(r_addr),
      .rdin_in(r_din), .rd_out(r_dout));

   task automatic wrap_up();
      $display("checks %0d errors %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   // release answers are checked on the index only
   task automatic host_cmd(input op_e op, input int idx, input logic gr, input logic full);
      while (cmd_ready_out !== 1'b1) @(posedge clk_in) #1;
      exp_q.push_back({full, gr, ~gr, idx[2:0]});
      cmd_valid_in = 1'b1;
      cmd_in = cmd_s'{op, idx[2:0]};
      @(posedge clk_in) #1;
      cmd_valid_in = 1'b0;
      do @(posedge clk_in) #1; while (rsp_valid_out !== 1'b1);
   endtask

   // junk on upper address and data bits must not matter
   task automatic r_wr(input int idx, input logic b);
      r_sel_n = 1'b0;
      r_we_n = 1'b0;
      r_addr = (`ADDR_W)'($random(seed));
      r_addr[2:0] = idx[2:0];
      r_din = (`DATA_W)'($random(seed));
      r_din[0] = b;
      @(posedge clk_in) #1;
      r_sel_n = 1'b1;
      r_we_n = 1'b1;
      // one idle edge so a following access never re-lowers a strobe in this step
      @(posedge clk_in) #1;
   endtask

   task automatic r_rd(input int idx, input logic ex, input logic hold);
      r_sel_n = 1'b0;
      r_oe_n = 1'b0;
      r_addr[2:0] = idx[2:0];
      @(posedge clk_in) #1;
      `CHK("right_flag", {`DATA_W{ex}}, r_dout)
      if (!hold) begin
         r_sel_n = 1'b1;
         r_oe_n = 1'b1;
         @(posedge clk_in) #1;
      end
   endtask

   // look mid-cycle, where the one-cycle answer pulse has settled
   always @(negedge clk_in) begin
      if (rsp_valid_out === 1'b1) begin
         e = (exp_q.size() > 0) ? exp_q.pop_front() : 6'h3F;
         if (e[5])
            `CHK("rsp", e[4:0], rsp_out)
         else
            `CHK("rsp_idx", e[2:0], rsp_out.idx)
      end
   end

   initial begin
      #80000;
      error_cnt++;
      $display("wrong value watchdog exp 0 got 1");
      wrap_up();
   end

   initial begin
      {cmd_valid_in, arst_n_in, cmd_in, r_addr, r_din} = '0;
      {r_sel_n, r_oe_n, r_we_n} = 3'b111;
      repeat (16) @(posedge clk_in) #1;
      arst_n_in = 1'b1;
      for (int i = 0; i < 8; i++) r_wr(i, 1'b1);
      `CHK("init_done", 1'b0, init_done_out)
      while (init_done_out !== 1'b1) @(posedge clk_in) #1;
      // far side can take every flag only if the host freed them at start-up
      for (int i = 0; i < 8; i++) begin
         r_rd(i, 1'b1, 1'b0);
         r_wr(i, 1'b0);
         r_rd(i, 1'b0, 1'b0);
         r_wr(i, 1'b1);
      end
      k = {$random(seed)} % 8;
      for (int i = 0; i < 8; i++) begin
         host_cmd(OP_ACQUIRE, (i + k) % 8, 1'b1, 1'b1);
         r_rd((i + k) % 8, 1'b1, 1'b0);
      end
      for (int i = 0; i < 8; i++) begin
         host_cmd(OP_RELEASE, i, 1'b0, 1'b0);
         r_wr(i, 1'b0);
         r_rd(i, 1'b0, 1'b0);
         r_wr(i, 1'b1);
      end
      k = {$random(seed)} % 8;
      r_wr(k, 1'b0);
      host_cmd(OP_ACQUIRE, k, 1'b0, 1'b1);
      host_cmd(OP_POLL, k, 1'b0, 1'b1);
      r_wr(k, 1'b1);
      host_cmd(OP_POLL, k, 1'b1, 1'b1);
      r_rd(k, 1'b1, 1'b0);
      r_wr(k, 1'b0);
      r_rd(k, 1'b1, 1'b1);
      host_cmd(OP_RELEASE, k, 1'b0, 1'b0);
      r_rd(k, 1'b1, 1'b0);
      r_rd(k, 1'b0, 1'b0);
      host_cmd(OP_POLL, k, 1'b0, 1'b1);
      r_wr(k, 1'b1);
      host_cmd(OP_ACQUIRE, k, 1'b1, 1'b1);
      // init opcode is a plain write of one and must free the held flag
      host_cmd(OP_INIT, k, 1'b0, 1'b0);
      r_wr(k, 1'b0);
      r_rd(k, 1'b0, 1'b0);
      repeat (4) @(posedge clk_in) #1;
      wrap_up();
   end
endmodule
